// [spi_host_pkg.sv]
package spi_host_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_LENGTH = 8'h04;
  localparam logic [7:0] OFS_CLOCKING = 8'h08;
  localparam logic [7:0] OFS_RECEIVE = 8'h0C;
  localparam logic [7:0] OFS_TRANSMIT = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_FRAME_ADDRESS = 8'h30;
  localparam logic [7:0] OFS_OPCODE_OPTION = 8'h34;
  localparam logic [7:0] OFS_FRAME_LAYOUT = 8'h38;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int BIT_FRAME_DONE = 10;
  localparam int BIT_SELECT_RELEASE = 8;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_SEND_COMPLETE = 2;
  localparam int BIT_SEND_EMPTY = 1;
  localparam int BIT_RECEIVE_FULL = 0;
  localparam int BIT_SELECT_STATE = 9;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_PHASE = 1;
  localparam int BIT_POLARITY = 0;
  localparam int LSB_DATA_LENGTH = 8;
  localparam int LSB_OPCODE = 0;
  localparam int LSB_OPTION = 16;
  localparam int BIT_DATA_EN = 7;
  localparam int BIT_OPTION_EN = 6;
  localparam int BIT_ADDRESS_EN = 5;
  localparam int BIT_OPCODE_EN = 4;
  localparam int BIT_ADDRESS_LONG = 10;
  localparam int LSB_OPTION_LEN = 8;
  localparam logic [31:0] FLAG_MASK = 32'h0000050F;
  localparam logic [31:0] LAYOUT_MASK = 32'h001FF7F7;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam int SCK_HALF_CYCLES = 6; // Must outlast the input synchroniser.

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [63:0] bits;
    logic [6:0] count;
    logic phase;
  } job_t;

endpackage : spi_host_pkg

// [sync3.sv]
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Three stages; a bit only changes once stages two and three agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= (stage2 & ~(stage2 ^ stage3)) | (sync_out & (stage2 ^ stage3));
    end
  end

endmodule : sync3

// [link_shifter.sv]
`timescale 1ns/1ps
module link_shifter
  import spi_host_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
) (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic go_toggle,
  input wire job_t job,
  input wire logic polarity,
  input wire logic data_in,
  output logic sck,
  output logic select_n,
  output logic data_out,
  output logic done_toggle,
  output logic [15:0] rx_word
);

  typedef enum {IDLE, SETUP, RUN, HOLD} link_state_t;

  link_state_t state;
  logic s_go;
  logic s_pol;
  logic s_din;
  logic go_seen;
  logic active;
  logic phase;
  logic [7:0] timer;
  logic [7:0] edges;
  logic [63:0] sr;
  logic [15:0] rx_sr;
  logic tick;

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------
  sync3 #(.WIDTH(3), .RESET_VALUE(3'h0)) u_sync (
    .clk(link_clk),
    .resetn(resetn),
    .async_in({go_toggle, polarity, data_in}),
    .sync_out({s_go, s_pol, s_din})
  );

  // Sampled data trails its pin by four clocks, so HALF below five reads stale bits.
  assign tick = (timer == 8'(HALF - 1));

  // Frame sequencer; the job word is stable while the go toggle crosses.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      go_seen <= 1'b0;
      active <= 1'b0;
      phase <= 1'b0;
      timer <= 8'h00;
      edges <= 8'h00;
      sr <= 64'h0000000000000000;
      rx_sr <= 16'h0000;
      rx_word <= 16'h0000;
      sck <= 1'b0;
      select_n <= 1'b1;
      data_out <= 1'b0;
      done_toggle <= 1'b0;
    end else begin
      timer <= tick ? 8'h00 : timer + 8'h01;
      case (state)
        IDLE: begin
          sck <= s_pol;
          active <= 1'b0;
          timer <= 8'h00;
          if (s_go != go_seen) begin
            go_seen <= s_go;
            sr <= job.bits;
            edges <= {job.count, 1'b0};
            phase <= job.phase;
            data_out <= job.bits[63];
            select_n <= 1'b0;
            state <= SETUP;
          end
        end
        SETUP: begin
          if (tick) begin
            state <= (edges == 8'h00) ? HOLD : RUN;
          end
        end
        RUN: begin
          if (tick) begin
            active <= ~active;
            sck <= s_pol ^ ~active;
            edges <= edges - 8'h01;
            if (~active ^ phase) begin
              rx_sr <= {rx_sr[14:0], s_din};
            end else if (phase) begin
              data_out <= sr[63];
              sr <= {sr[62:0], 1'b0};
            end else begin
              data_out <= sr[62];
              sr <= {sr[62:0], 1'b0};
            end
            if (edges == 8'h01) begin
              state <= HOLD;
            end
          end
        end
        HOLD: begin
          if (tick) begin
            select_n <= 1'b1;
            rx_word <= rx_sr;
            done_toggle <= ~done_toggle;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

endmodule : link_shifter

// [quad_spi_host_regs.sv]
`timescale 1ns/1ps
module quad_spi_host_regs
  import spi_host_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic irq_request,
  output logic sck,
  output logic select_n,
  output logic data_out,
  input wire logic data_in
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic enable;
  logic enable_prev;
  logic clock_phase;
  logic clock_polarity;
  logic [3:0] data_length;
  logic [31:0] frame_address;
  logic [7:0] memory_opcode;
  logic [7:0] memory_option_byte;
  logic [31:0] frame_layout;
  logic [31:0] irq_enable;
  logic [31:0] irq_flags;
  logic [15:0] receive_word;
  logic [15:0] transmit_word;
  logic tx_pending;
  logic busy;
  logic go_toggle;
  job_t job;
  logic done_seen;
  logic select_prev;

  // Signals from the link domain and decoded strobes.
  logic s_done;
  logic s_done_raw;
  logic s_select_n;
  logic [15:0] link_rx;
  logic wr;
  logic rd;
  logic start;
  logic done_evt;
  logic rx_load;
  logic [4:0] data_bits;
  logic [15:0] rx_mask;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;
  logic [31:0] next_rdata;

  assign wr = reg_req.sel & reg_req.write;
  assign rd = reg_req.sel & ~reg_req.write;

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------

  // Length field 0..8 means 8..16 bits; reserved codes are clamped to 16.
  function automatic logic [4:0] length_bits(input logic [3:0] code);
    length_bits = (code > 4'h8) ? 5'h10 : 5'({1'b0, code} + 5'h08);
  endfunction : length_bits

  // Packs the enabled phases, most significant bit first, into one stream.
  function automatic job_t build_job(
    input logic [7:0] op,
    input logic [7:0] opt,
    input logic [31:0] adr,
    input logic [15:0] dat,
    input logic [31:0] lay,
    input logic [3:0] dlen,
    input logic ph
  );
    logic [63:0] v;
    logic [6:0] n;
    logic [3:0] olen;
    logic [4:0] dbits;
    v = 64'h0000000000000000;
    n = 7'h00;
    olen = 4'h1 << lay[LSB_OPTION_LEN +: 2];
    dbits = length_bits(dlen);
    if (lay[BIT_OPCODE_EN]) begin
      v = v | ({op, 56'h00000000000000} >> n);
      n = n + 7'h08;
    end
    if (lay[BIT_OPTION_EN]) begin
      v = v | (({opt, 56'h00000000000000} << (4'h8 - olen)) >> n);
      n = n + 7'({3'h0, olen});
    end
    if (lay[BIT_ADDRESS_EN]) begin
      if (lay[BIT_ADDRESS_LONG]) begin
        v = v | ({adr, 32'h00000000} >> n);
        n = n + 7'h20;
      end else begin
        v = v | ({adr[23:0], 40'h0000000000} >> n);
        n = n + 7'h18;
      end
    end
    if (lay[BIT_DATA_EN]) begin
      // Only the low data_bits of the word leave the shifter.
      v = v | (({dat, 48'h000000000000} << (5'h10 - dbits)) >> n);
      n = n + 7'({2'h0, dbits});
    end
    build_job.bits = v;
    build_job.count = n;
    build_job.phase = ph;
  endfunction : build_job

  // ----------------------------------------------------------------
  // Link side and crossings back
  // ----------------------------------------------------------------
  link_shifter #(.HALF(HALF)) u_link (
    .link_clk(link_clk),
    .resetn(resetn),
    .go_toggle(go_toggle),
    .job(job),
    .polarity(clock_polarity),
    .data_in(data_in),
    .sck(sck),
    .select_n(select_n),
    .data_out(data_out),
    .done_toggle(s_done_raw),
    .rx_word(link_rx)
  );

  // Done arrives as a toggle, select as a level; both pass three stages.
  sync3 #(.WIDTH(2), .RESET_VALUE(2'h2)) u_back (
    .clk(ref_clk),
    .resetn(resetn),
    .async_in({select_n, s_done_raw}),
    .sync_out({s_select_n, s_done})
  );

  // The link result word is held until the next go, so it is read directly
  // once the done toggle has crossed; it is stable by then.
  assign done_evt = (s_done != done_seen);
  assign start = enable & tx_pending & ~busy;
  assign rx_load = done_evt & frame_layout[BIT_DATA_EN];
  assign data_bits = length_bits(data_length);
  assign rx_mask = 16'hFFFF >> (5'h10 - data_bits);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Plain read/write configuration written by software.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable <= 1'b0;
      clock_phase <= 1'b0;
      clock_polarity <= 1'b0;
      data_length <= 4'h0;
      frame_address <= RESET_WORD;
      memory_opcode <= 8'h00;
      memory_option_byte <= 8'h00;
      frame_layout <= RESET_WORD;
    end else if (wr) begin
      case (reg_req.addr)
        OFS_CONTROL: enable <= reg_req.wdata[BIT_ENABLE];
        OFS_LENGTH: data_length <= reg_req.wdata[LSB_DATA_LENGTH +: 4];
        OFS_CLOCKING: begin
          clock_phase <= reg_req.wdata[BIT_PHASE];
          clock_polarity <= reg_req.wdata[BIT_POLARITY];
        end
        OFS_FRAME_ADDRESS: frame_address <= reg_req.wdata;
        OFS_OPCODE_OPTION: begin
          memory_opcode <= reg_req.wdata[LSB_OPCODE +: 8];
          memory_option_byte <= reg_req.wdata[LSB_OPTION +: 8];
        end
        OFS_FRAME_LAYOUT: frame_layout <= reg_req.wdata & LAYOUT_MASK;
        default: ;
      endcase
    end
  end

  // Interrupt enables: one shared state behind a set and a clear port.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_enable <= RESET_WORD;
    end else if (wr && reg_req.addr == OFS_IRQ_ENABLE_CLEAR) begin
      irq_enable <= irq_enable & ~(reg_req.wdata & FLAG_MASK);
    end else if (wr && reg_req.addr == OFS_IRQ_ENABLE_SET) begin
      irq_enable <= irq_enable | (reg_req.wdata & FLAG_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Transmit word and frame launch
  // ----------------------------------------------------------------

  // A frame starts whenever enable is set, a word waits and the engine is free. Writing
  // over a waiting word replaces it; there is no second buffer slot.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_word <= 16'h0000;
      tx_pending <= 1'b0;
      busy <= 1'b0;
      go_toggle <= 1'b0;
      job <= '0;
      done_seen <= 1'b0;
    end else begin
      done_seen <= s_done;
      if (start) begin
        job <= build_job(memory_opcode, memory_option_byte, frame_address,
                         transmit_word, frame_layout, data_length, clock_phase);
        go_toggle <= ~go_toggle;
        busy <= 1'b1;
      end else if (done_evt) begin
        busy <= 1'b0;
      end
      if (wr && reg_req.addr == OFS_TRANSMIT) begin
        transmit_word <= reg_req.wdata[15:0];
        tx_pending <= 1'b1;
      end else if (start) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive word
  // ----------------------------------------------------------------

  // Unused upper bits are masked here so software never sees stale bits.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      receive_word <= 16'h0000;
    end else if (rx_load) begin
      receive_word <= link_rx & rx_mask;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------

  // Hardware events that set flags this cycle.
  always_comb begin
    flag_set = RESET_WORD;
    flag_set[BIT_FRAME_DONE] = done_evt;
    flag_set[BIT_SELECT_RELEASE] = s_select_n & ~select_prev;
    flag_set[BIT_OVERRUN] = rx_load & irq_flags[BIT_RECEIVE_FULL];
    flag_set[BIT_SEND_COMPLETE] = done_evt & ~tx_pending & ~start;
    flag_set[BIT_SEND_EMPTY] = start | (enable & ~enable_prev);
    flag_set[BIT_RECEIVE_FULL] = rx_load;
  end

  // Clears from software; a set in the same cycle still wins below.
  always_comb begin
    flag_clr = RESET_WORD;
    if (wr && reg_req.addr == OFS_IRQ_FLAGS) begin
      flag_clr = reg_req.wdata & FLAG_MASK;
    end
    if (rd && reg_req.addr == OFS_RECEIVE) begin
      flag_clr[BIT_RECEIVE_FULL] = 1'b1;
    end
  end

  // A transmit write beats a same-cycle completion, and disabling holds
  // the empty flag low, so those two override the usual set-wins order.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_flags <= RESET_WORD;
      select_prev <= 1'b1;
      enable_prev <= 1'b0;
    end else begin
      select_prev <= s_select_n;
      enable_prev <= enable;
      irq_flags <= ((irq_flags & ~flag_clr) | flag_set) & FLAG_MASK;
      if (wr && reg_req.addr == OFS_TRANSMIT) begin
        irq_flags[BIT_SEND_COMPLETE] <= 1'b0;
        irq_flags[BIT_SEND_EMPTY] <= 1'b0;
      end
      if (!enable) begin
        irq_flags[BIT_SEND_EMPTY] <= 1'b0;
      end
    end
  end

  // The request line is registered, so it trails the flag by one cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= |(irq_flags & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unmapped and write-only offsets read as zero.
  always_comb begin
    next_rdata = RESET_WORD;
    case (reg_req.addr)
      OFS_CONTROL: next_rdata[BIT_ENABLE] = enable;
      OFS_LENGTH: next_rdata[LSB_DATA_LENGTH +: 4] = data_length;
      OFS_CLOCKING: begin
        next_rdata[BIT_PHASE] = clock_phase;
        next_rdata[BIT_POLARITY] = clock_polarity;
      end
      OFS_RECEIVE: next_rdata[15:0] = receive_word;
      OFS_IRQ_ENABLE_CLEAR: next_rdata = irq_enable;
      OFS_IRQ_ENABLE_SET: next_rdata = irq_enable;
      OFS_IRQ_FLAGS: next_rdata = irq_flags;
      OFS_STATUS: begin
        next_rdata[BIT_SELECT_STATE] = s_select_n;
        next_rdata[BIT_ENABLE] = enable;
      end
      OFS_FRAME_ADDRESS: next_rdata = frame_address;
      OFS_OPCODE_OPTION: begin
        next_rdata[LSB_OPCODE +: 8] = memory_opcode;
        next_rdata[LSB_OPTION +: 8] = memory_option_byte;
      end
      OFS_FRAME_LAYOUT: next_rdata = frame_layout;
      default: next_rdata = RESET_WORD;
    endcase
  end

  // Read data is registered and held until the next read.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RESET_WORD;
    end else if (rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : quad_spi_host_regs

// [quad_spi_host_regs_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks for the host register block
// ----------------------------------------------------------------
module quad_spi_host_regs_chk
  import spi_host_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic irq_request,
  input wire logic sck,
  input wire logic select_n,
  input wire logic data_out,
  input wire logic data_in
);
  logic [31:0] en_copy;
  logic run_copy;
  logic sel_prev;
  logic [3:0] sel_age;
  wire wr = reg_req.sel && reg_req.write;
  wire rd = reg_req.sel && !reg_req.write;
  wire [7:0] ad = reg_req.addr;
  // Shadow of the interrupt enables, rebuilt from the writes seen on the bus.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_copy <= '0;
    end else if (wr && ad == OFS_IRQ_ENABLE_SET) begin
      en_copy <= en_copy | (reg_req.wdata & FLAG_MASK);
    end else if (wr && ad == OFS_IRQ_ENABLE_CLEAR) begin
      en_copy <= en_copy & ~reg_req.wdata;
    end
  end
  // Shadow of the interface enable bit.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_copy <= 1'b0;
    end else if (wr && ad == OFS_CONTROL) begin
      run_copy <= reg_req.wdata[BIT_ENABLE];
    end
  end
  // Age of the select level, because the status path lags by a synchroniser.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_prev <= 1'b1;
      sel_age <= 4'h0;
    end else begin
      sel_prev <= select_n;
      if (select_n != sel_prev) begin
        sel_age <= 4'h0;
      end else if (sel_age != 4'hF) begin
        sel_age <= sel_age + 4'h1;
      end
    end
  end
  a_en_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && (ad == OFS_IRQ_ENABLE_SET || ad == OFS_IRQ_ENABLE_CLEAR)
    |=> reg_rdata == $past(en_copy)) else $error("enable readback differs from shadow");
  a_flag_layout: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && ad == OFS_IRQ_FLAGS |=> (reg_rdata & ~FLAG_MASK) == 32'h00000000)
    else $error("flag word has bits outside the layout");
  a_rx_upper_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && ad == OFS_RECEIVE |=> reg_rdata[31:16] == 16'h0000)
    else $error("receive word upper half not zero");
  a_irq_gated: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq_request |-> ($past(en_copy) != 32'h0 || en_copy != 32'h0))
    else $error("interrupt request with no enable set");
  a_clear_quiets: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr && ad == OFS_IRQ_ENABLE_CLEAR && (reg_req.wdata & FLAG_MASK) == FLAG_MASK
    |=> ##[0:2] !irq_request) else $error("request stays up after all enables cleared");
  a_select_state: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && ad == OFS_STATUS && sel_age >= 4'h8
    |=> reg_rdata[BIT_SELECT_STATE] == $past(select_n))
    else $error("select state bit disagrees with the select line");
  a_complete_drops: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr && ad == OFS_TRANSMIT) ##1 (rd && ad == OFS_IRQ_FLAGS)
    |=> !reg_rdata[BIT_SEND_COMPLETE]) else $error("send complete still set after a write");
  a_empty_disabled: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd && ad == OFS_IRQ_FLAGS && !run_copy && !$past(run_copy)
    |=> !reg_rdata[BIT_SEND_EMPTY]) else $error("send empty set while disabled");
  a_sck_quiet_edges: assert property (@(posedge link_clk) disable iff (!resetn)
    $fell(select_n) |=> $stable(sck)) else $error("serial clock moved at select fall");
endmodule : quad_spi_host_regs_chk

bind quad_spi_host_regs quad_spi_host_regs_chk #(.HALF(HALF)) u_chk (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .link_clk(link_clk),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .irq_request(irq_request),
  .sck(sck),
  .select_n(select_n),
  .data_out(data_out),
  .data_in(data_in)
);

// [flash_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial memory stand-in
// ----------------------------------------------------------------
module flash_model (
  input wire logic sck,
  input wire logic select_n,
  input wire logic data_out,
  input wire logic pha,
  input wire logic pol,
  input wire logic [63:0] reply,
  output logic data_in,
  output logic [63:0] got,
  output logic [7:0] nbits
);
  logic [63:0] sh;
  initial begin
    data_in = 1'b0;
    got = '0;
    nbits = '0;
    sh = '0;
  end
  // A new frame reloads the reply; phase 0 needs its first bit before any edge.
  always @(negedge select_n) begin
    sh = reply;
    got = '0;
    nbits = '0;
    if (!pha) begin
      data_in = sh[63];
      sh = sh << 1;
    end
  end
  // A released line flips, so a stale bit never passes for a good one.
  always @(posedge select_n) data_in = ~data_in;
  // Capture on the sampling edge, move the reply on the other edge.
  always @(sck) begin
    if (select_n === 1'b0) begin
      if ((sck !== pol) ^ pha) begin
        got = {got[62:0], data_out};
        nbits = nbits + 8'h01;
      end else begin
        data_in = sh[63];
        sh = sh << 1;
      end
    end
  end
endmodule : flash_model

// [tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register level bench
// ----------------------------------------------------------------
module tb;
  import spi_host_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic pha = 1'b0;
  logic pol = 1'b0;
  reg_req_t reg_req = '0;
  logic [31:0] rdata;
  logic [31:0] reg_rdata;
  logic [63:0] reply = '0;
  logic [63:0] got;
  logic [63:0] mask;
  logic [7:0] nbits;
  logic [7:0] ofs [5] = '{8'h14, 8'h18, 8'h1C, 8'h30, 8'h24};
  logic [3:0] lens [4] = '{4'h0, 4'h3, 4'h8, 4'h5};
  logic irq_request;
  logic sck;
  logic select_n;
  logic data_out;
  logic data_in;
  int fails = 0;
  int samples_checked = 0;
  int n;
  // Register clock, and a link clock at an unrelated phase.
  always #50 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  quad_spi_host_regs #(.HALF(6)) dut (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_request(irq_request), .sck(sck),
    .select_n(select_n), .data_out(data_out), .data_in(data_in));
  flash_model mem (.sck(sck), .select_n(select_n), .data_out(data_out), .pha(pha), .pol(pol),
    .reply(reply), .data_in(data_in), .got(got), .nbits(nbits));
  // Bus cycles hold the request from a falling edge through the taking edge.
  task req(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_req = '{sel: 1'b1, write: w, addr: a, wdata: d};
    @(posedge ref_clk);
  endtask : req
  task idle;
    @(negedge ref_clk);
    reg_req.sel = 1'b0;
  endtask : idle
  task wr(input logic [7:0] a, input logic [31:0] d);
    req(1'b1, a, d);
    idle;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    req(1'b0, a, 32'h00000000);
    idle;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task chk(input string name, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : chk
  task end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Polls the flags under a bound until every bit of the mask is up.
  task wait_flags(input logic [31:0] m);
    for (int i = 0; i < 200; i++) begin
      rd(OFS_IRQ_FLAGS, rdata);
      if ((rdata & m) == m) break;
    end
    chk("flags reached", m, rdata & m);
  endtask : wait_flags
  // One frame: flags read straight after the write, status while selected.
  task frame(input logic [31:0] tx);
    int i;
    req(1'b1, OFS_TRANSMIT, tx);
    req(1'b0, OFS_IRQ_FLAGS, 32'h00000000);
    idle;
    @(negedge ref_clk);
    chk("complete after write", 1'b0, reg_rdata[BIT_SEND_COMPLETE]);
    for (i = 0; i < 50 && select_n !== 1'b0; i++) @(negedge ref_clk);
    repeat (10) @(negedge ref_clk);
    rd(OFS_STATUS, rdata);
    chk("select busy", 1'b0, rdata[BIT_SELECT_STATE]);
    wait_flags(32'h00000500);
    wr(OFS_IRQ_FLAGS, 32'h00000500);
  endtask : frame
  // Watchdog sized well past the expected run of under two thousand cycles.
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    end_sim;
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], rdata);
      chk("reset word", 32'h00000000, rdata);
    end
    wr(OFS_IRQ_ENABLE_SET, 32'hFFFFFFFF);
    rd(OFS_IRQ_ENABLE_CLEAR, rdata);
    chk("enables set", FLAG_MASK, rdata);
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000000C);
    wr(OFS_IRQ_ENABLE_CLEAR, 32'h00000000);
    rd(OFS_IRQ_ENABLE_SET, rdata);
    chk("enables cleared", 32'h00000503, rdata);
    wr(OFS_CONTROL, 32'h00000002);
    rd(OFS_IRQ_FLAGS, rdata);
    chk("empty on enable", 1'b1, rdata[BIT_SEND_EMPTY]);
    chk("irq raised", 1'b1, irq_request);
    wr(OFS_IRQ_FLAGS, 32'h00000002);
    rd(OFS_IRQ_FLAGS, rdata);
    chk("empty cleared", 1'b0, rdata[BIT_SEND_EMPTY]);
    wr(OFS_IRQ_ENABLE_CLEAR, 32'hFFFFFFFF);
    repeat (2) @(negedge ref_clk);
    chk("irq masked", 1'b0, irq_request);
    wr(OFS_FRAME_ADDRESS, 32'h1234ABCD);
    wr(OFS_OPCODE_OPTION, 32'h005A00C3);
    wr(OFS_FRAME_LAYOUT, 32'h000007F0);
    for (int m = 0; m < 4; m++) begin
      n = lens[m] + 8;
      mask = (64'h1 << n) - 64'h1;
      pol = m[0];
      pha = m[1];
      wr(OFS_CLOCKING, m);
      wr(OFS_LENGTH, {20'h00000, lens[m], 8'h00});
      reply = (64'h3C96 & mask) << (16 - n);
      repeat (10) @(negedge ref_clk);
      chk("idle clock", pol, sck);
      frame(32'h0000BEEF);
      chk("bit count", 48 + n, nbits);
      chk("frame bits", ({16'h0000, 8'hC3, 8'h5A, 32'h1234ABCD} << n) | (64'hBEEF & mask), got);
      rd(OFS_IRQ_FLAGS, rdata);
      chk("done flags", 32'h00000007, rdata & 32'h0000000F);
      rd(OFS_RECEIVE, rdata);
      chk("receive word", 64'h3C96 & mask, rdata);
      rd(OFS_IRQ_FLAGS, rdata);
      chk("full after read", 1'b0, rdata[BIT_RECEIVE_FULL]);
      rd(OFS_STATUS, rdata);
      chk("select idle", 1'b1, rdata[BIT_SELECT_STATE]);
      wr(OFS_IRQ_FLAGS, 32'hFFFFFFFF);
      rd(OFS_IRQ_FLAGS, rdata);
      chk("flags cleared", 32'h00000000, rdata);
    end
    frame(32'h00001111);
    frame(32'h00002222);
    rd(OFS_IRQ_FLAGS, rdata);
    chk("overrun", 1'b1, rdata[BIT_OVERRUN]);
    wr(OFS_CONTROL, 32'h00000000);
    repeat (2) @(negedge ref_clk);
    rd(OFS_IRQ_FLAGS, rdata);
    chk("empty disabled", 1'b0, rdata[BIT_SEND_EMPTY]);
    end_sim;
  end
endmodule : tb
